// File: verilog/ncs_pkg.sv
// package for the oscillator phase sync and reference divisor block
package ncs_pkg;
  localparam int unsigned ADDR_W = 12;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_PRESET_SEL = 12'h215;
  localparam logic [11:0] IDX_REF_DIV = 12'h217;
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h219;
  localparam logic [11:0] IDX_SYNC_STAT = 12'h21A;
  localparam logic [11:0] IDX_FREQ_A0 = 12'h220;
  localparam logic [11:0] IDX_PHASE_A0 = 12'h224;
  localparam logic [11:0] ADDR_PRESET_SEL = 12'h854;
  localparam logic [11:0] ADDR_REF_DIV = 12'h85C;
  localparam logic [11:0] ADDR_SYNC_CTRL = 12'h864;
  localparam logic [11:0] ADDR_SYNC_STAT = 12'h868;
  localparam logic [11:0] ADDR_FREQ_A0 = 12'h880;
  localparam logic [11:0] ADDR_PHASE_A0 = 12'h890;
  // field positions and reset values
  localparam int unsigned BIT_INIT_ON_SYNC = 1;
  localparam int unsigned BIT_NEXT_SYSREF_ARM = 0;
  localparam logic [1:0] RST_PRESET_SEL = 2'h0;
  localparam logic [15:0] RST_REF_DIV = 16'h0000;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h02;
  localparam logic [31:0] RST_FREQ_A0 = 32'hC0000000;
  localparam logic [15:0] RST_PHASE_A0 = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus master to slave
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } ncs_axi_req_t;

  // bus slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ncs_axi_rsp_t;

  // all state of the top module
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] preset_sel;
    logic [15:0] ref_div;
    logic [7:0] sync_ctrl;
    logic [31:0] freq_a0;
    logic [15:0] phase_a0;
    logic sync_n_prev;
    logic sysref_prev;
    logic sync_pending;
    logic sysref_armed;
  } ncs_top_state_t;

  // all state of the accumulator
  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] div_cnt;
    logic [31:0] phase;
  } ncs_acc_state_t;
endpackage : ncs_pkg

// File: verilog/ncs_phase_acc.sv
// phase accumulator with reference divisor restart and phase offset
`timescale 1ns/10ps
`default_nettype none
module ncs_phase_acc
  import ncs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic [31:0] freq_word_in,
  input wire logic [15:0] phase_offset_in,
  input wire logic [15:0] ref_div_in,
  input wire logic phase_init_in,
  // phase
  output logic [31:0] phase_out
);
  ncs_acc_state_t s_q, s_d;

  // next state of accumulator and output phase
  always_comb begin
    s_d = s_q;
    s_d.acc = s_q.acc + freq_word_in;
    s_d.div_cnt = s_q.div_cnt + 16'h0001;
    // restart every divisor period so the rounding error never builds up
    if (ref_div_in != 16'h0000 && s_q.div_cnt >= ref_div_in - 16'h0001) begin
      s_d.acc = 32'h00000000;
      s_d.div_cnt = 16'h0000;
    end
    if (ref_div_in == 16'h0000) begin
      s_d.div_cnt = 16'h0000;
    end
    if (phase_init_in) begin
      s_d.acc = 32'h00000000;
      s_d.div_cnt = 16'h0000;
    end
    s_d.phase = s_d.acc + {phase_offset_in, 16'h0000};
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase_out = s_q.phase;
endmodule : ncs_phase_acc
`default_nettype wire

// File: verilog/ncs_top.sv
// register file, phase initialization control and oscillator of one channel
// Operation
// - divisor zero gives a plain 32-bit accumulating oscillator
// - one divisor value serves every configuration preset
// - with sync-request bit set, init phase at boundary after SYNC~ rises
// - in 64b/66b modes SYNC~ only initializes oscillator phase
// - writing arm bit zero then one arms for next SYSREF rising edge
// - after one SYSREF init, ignore SYSREF until re-armed
// - preset 0 frequency word is 32-bit RW, resets to C0000000
// - output frequency is word over two to the 32 times rate
// - 16-bit phase offset left-justified and added to accumulator
// - preset selector zero picks preset 0 words
`timescale 1ns/10ps
`default_nettype none
module ncs_top
  import ncs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire ncs_axi_req_t axi_req_in,
  output ncs_axi_rsp_t axi_rsp_out,
  // link and reference timing
  input wire logic sync_n_in,
  input wire logic frame_boundary_in,
  input wire logic link_64b66b_in,
  input wire logic sysref_in,
  // oscillator
  output logic [31:0] phase_out,
  output logic phase_init_out
);
  ncs_top_state_t s_q, s_d;
  logic wr_fire;
  logic sync_rise;
  logic sysref_rise;
  logic arm_write;
  logic init_by_sync;
  logic init_by_sysref;
  logic [31:0] act_freq;
  logic [15:0] act_phase;
  logic [7:0] new_ctrl;
  logic [31:0] m_sel;
  logic [31:0] m_div;
  logic [31:0] m_ctrl;
  logic [31:0] m_phase;

  // merge write data into an old register value by byte strobes
  function automatic logic [31:0] ncs_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction : ncs_merge

  // events seen on the bus, link and timing pins
  always_comb begin
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    sync_rise = sync_n_in && !s_q.sync_n_prev;
    sysref_rise = sysref_in && !s_q.sysref_prev;
    // merged words per register; a function result cannot be part-selected directly
    m_sel = ncs_merge({30'h00000000, s_q.preset_sel}, s_q.w_data, s_q.w_strb);
    m_div = ncs_merge({16'h0000, s_q.ref_div}, s_q.w_data, s_q.w_strb);
    m_ctrl = ncs_merge({24'h000000, s_q.sync_ctrl}, s_q.w_data, s_q.w_strb);
    m_phase = ncs_merge({16'h0000, s_q.phase_a0}, s_q.w_data, s_q.w_strb);
    new_ctrl = m_ctrl[7:0];
    // arming needs the bit seen at zero first, then a one written
    arm_write = wr_fire && s_q.aw_addr == ADDR_SYNC_CTRL
                && !s_q.sync_ctrl[BIT_NEXT_SYSREF_ARM] && new_ctrl[BIT_NEXT_SYSREF_ARM];
    // SYNC~ feeds nothing but this; link mode does not change its use
    init_by_sync = s_q.sync_pending && frame_boundary_in
                   && s_q.sync_ctrl[BIT_INIT_ON_SYNC];
    init_by_sysref = s_q.sysref_armed && sysref_rise;
  end

  // active preset; presets 1 to 3 live outside this block and read as zero
  always_comb begin
    if (s_q.preset_sel == 2'h0) begin
      act_freq = s_q.freq_a0;
      act_phase = s_q.phase_a0;
    end else begin
      act_freq = 32'h00000000;
      act_phase = 16'h0000;
    end
  end

  // next state: bus slave, registers and phase init flags
  always_comb begin
    s_d = s_q;
    s_d.sync_n_prev = sync_n_in;
    s_d.sysref_prev = sysref_in;
    // write address and data taken in either order
    if (axi_req_in.awvalid && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.w_data = axi_req_in.wdata;
      s_d.w_strb = axi_req_in.wstrb;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr == ADDR_PRESET_SEL) begin
        s_d.preset_sel = m_sel[1:0];
      end else if (s_q.aw_addr == ADDR_REF_DIV) begin
        s_d.ref_div = m_div[15:0];
      end else if (s_q.aw_addr == ADDR_SYNC_CTRL) begin
        s_d.sync_ctrl = new_ctrl;
      end else if (s_q.aw_addr == ADDR_FREQ_A0) begin
        s_d.freq_a0 = ncs_merge(s_q.freq_a0, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == ADDR_PHASE_A0) begin
        s_d.phase_a0 = m_phase[15:0];
      end else if (s_q.aw_addr == ADDR_SYNC_STAT) begin
        s_d.bresp = RESP_OKAY; // read-only, write ignored
      end else begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && axi_req_in.bready) begin
      s_d.bvalid = 1'b0;
    end
    // read channel: one read at a time
    if (axi_req_in.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h00000000;
      if (axi_req_in.araddr == ADDR_PRESET_SEL) begin
        s_d.rdata = {30'h00000000, s_q.preset_sel};
      end else if (axi_req_in.araddr == ADDR_REF_DIV) begin
        s_d.rdata = {16'h0000, s_q.ref_div};
      end else if (axi_req_in.araddr == ADDR_SYNC_CTRL) begin
        s_d.rdata = {24'h000000, s_q.sync_ctrl};
      end else if (axi_req_in.araddr == ADDR_SYNC_STAT) begin
        s_d.rdata = {30'h00000000, s_q.sync_pending, s_q.sysref_armed};
      end else if (axi_req_in.araddr == ADDR_FREQ_A0) begin
        s_d.rdata = s_q.freq_a0;
      end else if (axi_req_in.araddr == ADDR_PHASE_A0) begin
        s_d.rdata = {16'h0000, s_q.phase_a0};
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && axi_req_in.rready) begin
      s_d.rvalid = 1'b0;
    end
    // sync request waits for the next boundary; clearing the bit drops it
    if (init_by_sync) begin
      s_d.sync_pending = 1'b0;
    end
    if (sync_rise) begin
      s_d.sync_pending = 1'b1;
    end
    if (!s_q.sync_ctrl[BIT_INIT_ON_SYNC]) begin
      s_d.sync_pending = 1'b0;
    end
    // one SYSREF edge consumes the arm; a re-arm in the same cycle wins
    if (init_by_sysref) begin
      s_d.sysref_armed = 1'b0;
    end
    if (arm_write) begin
      s_d.sysref_armed = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.preset_sel <= RST_PRESET_SEL;
      s_q.ref_div <= RST_REF_DIV;
      s_q.sync_ctrl <= RST_SYNC_CTRL;
      s_q.freq_a0 <= RST_FREQ_A0;
      s_q.phase_a0 <= RST_PHASE_A0;
      s_q.sync_n_prev <= 1'b1; // idle high so reset release is no edge
    end else begin
      s_q <= s_d;
    end
  end

  // oscillator core; divisor is shared by all presets
  ncs_phase_acc i_ncs_phase_acc (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .freq_word_in(act_freq),
    .phase_offset_in(act_phase),
    .ref_div_in(s_q.ref_div),
    .phase_init_in(phase_init_out),
    .phase_out(phase_out)
  );

  // bus answers
  always_comb begin
    axi_rsp_out.awready = !s_q.aw_got && !s_q.bvalid;
    axi_rsp_out.wready = !s_q.w_got && !s_q.bvalid;
    axi_rsp_out.bvalid = s_q.bvalid;
    axi_rsp_out.bresp = s_q.bresp;
    axi_rsp_out.arready = !s_q.rvalid;
    axi_rsp_out.rvalid = s_q.rvalid;
    axi_rsp_out.rdata = s_q.rdata;
    axi_rsp_out.rresp = s_q.rresp;
  end

  assign phase_init_out = init_by_sync || init_by_sysref;
  // link mode only selects framing upstream; nothing here depends on it
  logic unused_mode;
  assign unused_mode = link_64b66b_in;
endmodule : ncs_top
`default_nettype wire

// File: dv/ncs_chk.sv
// port checker for the oscillator phase sync block
`timescale 1ns/10ps
`default_nettype none
module ncs_chk
  import ncs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bus and timing
  input wire ncs_axi_req_t axi_req_in,
  input wire ncs_axi_rsp_t axi_rsp_out,
  input wire logic sync_n_in,
  input wire logic frame_boundary_in,
  input wire logic link_64b66b_in,
  input wire logic sysref_in,
  // oscillator
  input wire logic [31:0] phase_out,
  input wire logic phase_init_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // bus handshakes, taken on valid and ready together
  sequence s_wr_take;
    axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready;
  endsequence
  sequence s_rd_take;
    axi_req_in.arvalid && axi_rsp_out.arready;
  endsequence
  property p_wr_ans;
    s_wr_take |-> ##[1:2] axi_rsp_out.bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_rd_take |=> axi_rsp_out.rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_once;
    axi_rsp_out.bvalid && axi_req_in.bready |=> !axi_rsp_out.bvalid;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write answer repeated");
  property p_rd_once;
    axi_rsp_out.rvalid && axi_req_in.rready |=> !axi_rsp_out.rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
  property p_aw_refuse;
    axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while answering");
  property p_ar_refuse;
    axi_rsp_out.rvalid |-> !axi_rsp_out.arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answering");
  // an init restarts from the offset, whose low half is always zero
  property p_init_phase;
    phase_init_out |=> phase_out[15:0] == 16'h0000;
  endproperty
  a_init_phase: assert property (p_init_phase) else $error("init left phase");
  // an init needs a boundary or a fresh sysref edge
  property p_init_cause;
    phase_init_out |-> frame_boundary_in || (sysref_in && !$past(sysref_in));
  endproperty
  a_init_cause: assert property (p_init_cause) else $error("init without cause");
endmodule : ncs_chk
bind ncs_top ncs_chk i_ncs_chk (.sys_clk_in, .rst_n_in, .axi_req_in, .axi_rsp_out, .sync_n_in,
  .frame_boundary_in, .link_64b66b_in, .sysref_in, .phase_out, .phase_init_out);
`default_nettype wire

// File: dv/ncs_link_model.sv
// link receiver and sysref source model
`timescale 1ns/10ps
`default_nettype none
module ncs_link_model #(
  parameter int FRAME_LEN = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bench commands
  input wire logic sync_req_in,
  input wire logic [3:0] sysref_cnt_in,
  input wire logic sysref_go_in,
  // timing outputs
  output logic sync_n_out,
  output logic frame_boundary_out,
  output logic sysref_out
);
  logic [7:0] frm_q;
  logic [4:0] pulse_q;
  // frame counter and pulse train; sysref idles low unless asked
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frm_q <= 8'h00;
      pulse_q <= 5'h00;
    end else begin
      frm_q <= (frm_q == 8'(FRAME_LEN - 1)) ? 8'h00 : frm_q + 8'h01;
      if (sysref_go_in) begin
        pulse_q <= {sysref_cnt_in, 1'b0};
      end else if (pulse_q != 5'h00) begin
        pulse_q <= pulse_q - 5'h01;
      end
    end
  end
  // odd counts give one-cycle pulses with gaps
  assign sysref_out = pulse_q[0];
  assign frame_boundary_out = (frm_q == 8'h00);
  assign sync_n_out = !sync_req_in;
endmodule : ncs_link_model
`default_nettype wire

// File: dv/tb_ncs_top.sv
// self-checking bench for the oscillator phase sync block
`timescale 1ns/10ps
`default_nettype none
module tb_ncs_top
  import ncs_pkg::*;
;
  localparam int FRAME_LEN = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ncs_axi_req_t req = '0;
  ncs_axi_rsp_t rsp;
  logic sync_req = 1'b1;
  logic go = 1'b0;
  logic [3:0] cnt = 4'h1;
  logic mode64 = 1'b0;
  logic sync_n;
  logic frame_b;
  logic sysref;
  logic init;
  logic [31:0] phase;
  int n_mismatch = 0;
  int n_compared = 0;
  // free-running clock
  always #5 clk = ~clk;
  ncs_top i_ncs_top (.sys_clk_in(clk), .rst_n_in(rst_n), .axi_req_in(req), .axi_rsp_out(rsp),
    .sync_n_in(sync_n), .frame_boundary_in(frame_b), .link_64b66b_in(mode64),
    .sysref_in(sysref), .phase_out(phase), .phase_init_out(init));
  ncs_link_model #(.FRAME_LEN(FRAME_LEN)) i_ncs_link_model (.sys_clk_in(clk), .rst_n_in(rst_n),
    .sync_req_in(sync_req), .sysref_cnt_in(cnt), .sysref_go_in(go), .sync_n_out(sync_n),
    .frame_boundary_out(frame_b), .sysref_out(sysref));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // one bus cycle; the answer carries the response and, on reads, the data
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (w ? rsp.bvalid : rsp.rvalid) break;
    end
    if (i == 30) begin
      n_mismatch++;
      test_done();
    end
    chk(32'(w ? rsp.bresp : rsp.rresp), 32'(e));
    if (!w) chk(rsp.rdata, d);
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic fire(input logic [3:0] c);
    cnt <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : fire
  // bounded wait for an init pulse, seen at the edge that ends its cycle
  task automatic wait_init(output int n);
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (init === 1'b1) break;
    end
    if (n == 40) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_init
  // count init pulses, or cycles with a given phase, over k cycles
  task automatic hits(input bit on_init, input logic [31:0] v, input int k, output int c);
    c = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (on_init ? (init === 1'b1) : (phase === v)) c++;
    end
  endtask : hits
  task automatic t_regs();
    bus(0, ADDR_REF_DIV, 32'h0, RESP_OKAY);
    bus(0, ADDR_SYNC_CTRL, 32'h2, RESP_OKAY);
    bus(0, ADDR_FREQ_A0, 32'hC0000000, RESP_OKAY);
    bus(0, ADDR_PRESET_SEL, 32'h0, RESP_OKAY);
    bus(1, ADDR_FREQ_A0, 32'h40000001, RESP_OKAY);
    bus(0, ADDR_FREQ_A0, 32'h40000001, RESP_OKAY);
    bus(1, 12'h000, 32'h0, RESP_SLVERR);
    bus(0, 12'h000, 32'h0, RESP_SLVERR);
  endtask : t_regs
  task automatic t_arm();
    int n;
    bus(1, ADDR_PHASE_A0, 32'h1234, RESP_OKAY);
    bus(0, ADDR_PHASE_A0, 32'h1234, RESP_OKAY);
    bus(1, ADDR_SYNC_CTRL, 32'h0, RESP_OKAY);
    bus(1, ADDR_SYNC_CTRL, 32'h1, RESP_OKAY);
    bus(0, ADDR_SYNC_STAT, 32'h1, RESP_OKAY);
    fire(4'h1);
    wait_init(n);
    for (n = 0; n < 4; n++) begin
      #1;
      chk(phase, 32'h12340000 + n * 32'h40000001);
      @(posedge clk);
    end
    fire(4'h3);
    hits(1, 0, 12, n);
    chk(n, 0);
    bus(0, ADDR_SYNC_STAT, 32'h0, RESP_OKAY);
    bus(1, ADDR_SYNC_CTRL, 32'h1, RESP_OKAY);
    fire(4'h1);
    hits(1, 0, 6, n);
    chk(n, 0);
    bus(1, ADDR_SYNC_CTRL, 32'h0, RESP_OKAY);
    bus(1, ADDR_SYNC_CTRL, 32'h1, RESP_OKAY);
    fire(4'h3);
    hits(1, 0, 12, n);
    chk(n, 1);
  endtask : t_arm
  task automatic t_div();
    int n;
    bus(1, ADDR_REF_DIV, 32'h4, RESP_OKAY);
    hits(0, 32'h12340000, 8, n);
    chk(n, 2);
    bus(1, ADDR_REF_DIV, 32'h0, RESP_OKAY);
  endtask : t_div
  task automatic t_sync();
    int n;
    int m;
    for (m = 0; m < 2; m++) begin
      mode64 <= m[0];
      bus(1, ADDR_SYNC_CTRL, 32'h2, RESP_OKAY);
      sync_req <= 1'b0;
      wait_init(n);
      chk(frame_b, 1'b1);
      chk(n <= FRAME_LEN + 1, 1'b1);
      sync_req <= 1'b1;
    end
    bus(1, ADDR_SYNC_CTRL, 32'h0, RESP_OKAY);
    sync_req <= 1'b0;
    hits(1, 0, 3 * FRAME_LEN, n);
    chk(n, 0);
  endtask : t_sync
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(phase, 32'h0);
    t_regs();
    t_arm();
    t_div();
    t_sync();
    test_done();
  end
endmodule : tb_ncs_top
`default_nettype wire
